// [rtl/lrd_pkg.sv]
// Purpose: shared constants for the differential lane receive deserializer
// Assumes: one system clock; serial and word clocks arrive as sampled pins
// Notes:   widths are in serial bits per parallel word
package lrd_pkg;

  localparam int unsigned MAX_WIDTH   = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned WIDTH_BITS  = 4;

  // legal deserialization widths; a width at or below one means bypass
  localparam logic [3:0]  WIDTH_BYPASS = 4'h1;
  localparam logic [3:0]  WIDTH_MIN    = 4'h2;
  localparam logic [3:0]  WIDTH_MAX    = 4'h8;

  // bit positions of the pin synchroniser vector
  localparam int unsigned SYNC_POS     = 0;
  localparam int unsigned SYNC_NEG     = 1;
  localparam int unsigned SYNC_BCLK    = 2;
  localparam int unsigned SYNC_WCLK    = 3;
  localparam int unsigned SYNC_COUNT   = 4;

  typedef enum logic [1:0] {
    LRD_MODE_DESER,
    LRD_MODE_BYPASS,
    LRD_MODE_ALT
  } lrd_mode_t;

endpackage

// [rtl/lrd_fifo.sv]
// Purpose: word buffer between the deserializer and the core
// Assumes: DEPTH is a power of two
// Notes:   read data always come from the output register stage
`timescale 1ns/1ps
module lrd_fifo #(
  parameter int unsigned WIDTH = lrd_pkg::MAX_WIDTH,
  parameter int unsigned DEPTH = lrd_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk_sys,   // system clock
  input  wire logic             i_rst_n,     // async reset, active low
  input  wire logic             i_in_valid,  // write request
  output logic                  o_in_ready,  // room in memory
  input  wire logic [WIDTH-1:0] i_in_data,   // write data
  output logic                  o_out_valid, // output stage holds a word
  input  wire logic             i_out_ready, // consumer takes the word
  output logic      [WIDTH-1:0] o_out_data   // registered read data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      cnt_r;
  logic             out_valid_r;
  logic [WIDTH-1:0] out_data_r;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign push        = i_in_valid && o_in_ready;
  assign pop         = (cnt_r != '0) && (!out_valid_r || i_out_ready);
  assign o_out_valid = out_valid_r;
  assign o_out_data  = out_data_r;

  always_ff @(posedge i_clk_sys) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else begin
      case ({push, pop})
        2'b10:   cnt_r <= cnt_r + (AW+1)'(1);
        2'b01:   cnt_r <= cnt_r - (AW+1)'(1);
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      out_valid_r <= 1'b0;
      out_data_r  <= '0;
    end else if (pop) begin
      out_valid_r <= 1'b1;
      out_data_r  <= mem_r[rd_ptr_r];
    end else if (i_out_ready) begin
      out_valid_r <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_fifo_bound:   assert property (cnt_r <= (AW+1)'(DEPTH))
    else $error("fifo count above depth");
  a_fifo_hold:    assert property (
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_data))
    else $error("fifo output changed while stalled");

endmodule

// [rtl/lrd_rx_deser.sv]
// Purpose: receive deserializer for one differential serial lane
// Assumes: bit and word clocks are far slower than the system clock
// Notes:   first received bit of a word lands in the highest used bit
`timescale 1ns/1ps
module lrd_rx_deser #(
  parameter int unsigned MAX_W      = lrd_pkg::MAX_WIDTH,
  parameter int unsigned FIFO_DEPTH = lrd_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk_sys,             // system clock, 40 MHz
  input  wire logic             i_rst_n,               // async reset, active low
  input  wire logic             i_diff_pos_pad,        // differential positive pad
  input  wire logic             i_diff_neg_pad,        // differential negative pad
  input  wire logic             i_serial_bit_clock,    // fast bit clock pin
  input  wire logic             i_parallel_word_clock, // slow word clock pin
  input  wire logic             i_deser_en,            // deserialization enable
  input  wire logic [3:0]       i_deser_width,         // bits per word, 1..8
  input  wire logic             i_conn_alt,            // alternate connection type
  input  wire logic             i_word_ready,          // core accepts word
  input  wire logic             i_overrun_clr,         // clears overrun flag
  output logic      [MAX_W-1:0] o_parallel_rx_word,    // received word
  output logic                  o_word_valid,          // word available
  output logic                  o_rx_bit,              // bypass bit
  output logic                  o_bypass_alt_out,      // alternate output
  output logic                  o_pll_ref_input,       // PLL reference feed
  output logic                  o_overrun              // word lost, sticky
);
  localparam int unsigned CNT_W = lrd_pkg::WIDTH_BITS;

  logic [lrd_pkg::SYNC_COUNT-1:0] sync1_r;
  logic [lrd_pkg::SYNC_COUNT-1:0] sync2_r;
  logic                           bclk_d_r;
  logic                           wclk_d_r;
  logic                           bit_edge;
  logic                           word_edge;
  logic                           rx_level;
  logic                           bypass;
  lrd_pkg::lrd_mode_t             mode;
  logic [CNT_W-1:0]               width_eff;
  logic [MAX_W-1:0]               width_mask;
  logic [MAX_W-1:0]               shift_r;
  logic [MAX_W-1:0]               shift_nxt;
  logic [CNT_W-1:0]               cnt_r;
  logic [CNT_W-1:0]               cnt_now;
  logic                           push;
  logic [MAX_W-1:0]               push_word;
  logic                           fifo_ready;
  logic                           rx_bit_r;
  logic                           alt_r;
  logic                           overrun_r;

  // two-stage synchroniser for every pin input
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_parallel_word_clock, i_serial_bit_clock, i_diff_neg_pad, i_diff_pos_pad};
      sync2_r <= sync1_r;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bclk_d_r <= 1'b0;
      wclk_d_r <= 1'b0;
    end else begin
      bclk_d_r <= sync2_r[lrd_pkg::SYNC_BCLK];
      wclk_d_r <= sync2_r[lrd_pkg::SYNC_WCLK];
    end
  end

  assign bit_edge  = sync2_r[lrd_pkg::SYNC_BCLK] && !bclk_d_r;
  assign word_edge = sync2_r[lrd_pkg::SYNC_WCLK] && !wclk_d_r;
  assign rx_level  = sync2_r[lrd_pkg::SYNC_POS] && !sync2_r[lrd_pkg::SYNC_NEG];

  // mode selection from the static configuration
  assign bypass    = !i_deser_en || (i_deser_width <= lrd_pkg::WIDTH_BYPASS);
  assign width_eff = (i_deser_width > lrd_pkg::WIDTH_MAX) ? lrd_pkg::WIDTH_MAX
                                                          : i_deser_width;

  always_comb begin
    if (!bypass) begin
      mode = lrd_pkg::LRD_MODE_DESER;
    end else if (i_conn_alt) begin
      mode = lrd_pkg::LRD_MODE_ALT;
    end else begin
      mode = lrd_pkg::LRD_MODE_BYPASS;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < MAX_W; gi++) begin : g_mask
      assign width_mask[gi] = (CNT_W'(gi) < width_eff);
    end
  endgenerate

  assign shift_nxt = bit_edge ? {shift_r[MAX_W-2:0], rx_level} : shift_r;
  assign cnt_now   = (bit_edge && cnt_r < width_eff) ? cnt_r + CNT_W'(1) : cnt_r;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= '0;
    end else begin
      shift_r <= shift_nxt;
    end
  end

  // bits gathered since the last word boundary, saturating at the width
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
    end else if (word_edge) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_now;
    end
  end

  // a word is complete only when the word clock rises after n bits
  assign push      = word_edge && (mode == lrd_pkg::LRD_MODE_DESER)
                     && (cnt_now >= width_eff);
  assign push_word = shift_nxt & width_mask;

  lrd_fifo #(
    .WIDTH (MAX_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push),
    .o_in_ready  (fifo_ready),
    .i_in_data   (push_word),
    .o_out_valid (o_word_valid),
    .i_out_ready (i_word_ready),
    .o_out_data  (o_parallel_rx_word)
  );

  // the lane cannot be stalled, so a full buffer loses the word
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun_r <= 1'b0;
    end else if (push && !fifo_ready) begin
      overrun_r <= 1'b1;
    end else if (i_overrun_clr) begin
      overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_bit_r <= 1'b0;
    end else begin
      rx_bit_r <= (mode == lrd_pkg::LRD_MODE_BYPASS) && rx_level;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_r <= 1'b0;
    end else begin
      alt_r <= (mode == lrd_pkg::LRD_MODE_ALT) && rx_level;
    end
  end

  assign o_rx_bit         = rx_bit_r;
  assign o_bypass_alt_out = alt_r;
  assign o_pll_ref_input  = alt_r;
  assign o_overrun        = overrun_r;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_word_masked:   assert property (push |-> (push_word & ~width_mask) == '0)
    else $error("word holds bits above the width");
  a_bypass_bit:    assert property (
    (mode == lrd_pkg::LRD_MODE_BYPASS) |=> o_rx_bit == $past(rx_level))
    else $error("bypass bit does not follow the pad");
  a_alt_only:      assert property (
    o_bypass_alt_out |-> $past(mode) == lrd_pkg::LRD_MODE_ALT)
    else $error("alternate output outside alternate mode");
  a_alt_no_data:   assert property (
    (mode == lrd_pkg::LRD_MODE_ALT) |-> !push ##1 !o_rx_bit)
    else $error("alternate mode delivered data");
  a_alt_follow:    assert property (
    (mode == lrd_pkg::LRD_MODE_ALT) |=> o_pll_ref_input == $past(rx_level))
    else $error("reference feed does not follow the pad");
  a_bit_sync:      assert property (
    bit_edge |-> $past(i_serial_bit_clock, 2) && !$past(i_serial_bit_clock, 3))
    else $error("bit edge not two cycles after pin rise");
  a_shift_in:      assert property (bit_edge |=> shift_r[0] == $past(rx_level))
    else $error("bit not shifted in on bit clock edge");
  a_push_edge:     assert property (push |-> word_edge && cnt_now >= width_eff)
    else $error("word pushed off a word boundary");
  a_word_cnt:      assert property (word_edge |=> cnt_r == '0)
    else $error("bit count not restarted at word boundary");
  a_width_range:   assert property (
    push |-> width_eff >= lrd_pkg::WIDTH_MIN && width_eff <= lrd_pkg::WIDTH_MAX)
    else $error("word pushed with illegal width");
  a_overrun_set:   assert property (push && !fifo_ready |=> o_overrun)
    else $error("lost word not flagged");
  a_overrun_hold:  assert property (o_overrun && !i_overrun_clr |=> o_overrun)
    else $error("overrun flag dropped without clear");
  a_deser_quiet:   assert property (
    (mode == lrd_pkg::LRD_MODE_DESER) |=> !o_rx_bit && !o_bypass_alt_out)
    else $error("single-bit outputs active while deserializing");
  a_bypass_drop:   assert property (bypass |-> !push)
    else $error("word pushed while bypassed");

  c_word_push:     cover property (push ##[1:4] o_word_valid);
  c_bypass_high:   cover property ((mode == lrd_pkg::LRD_MODE_BYPASS) ##1 o_rx_bit);
  c_alt_high:      cover property (o_pll_ref_input);
  c_overrun:       cover property (push && !fifo_ready);
  c_short_word:    cover property (word_edge && (cnt_now < width_eff));

endmodule

// [dv/lrd_tx_model.sv]
// Purpose: serial lane transmitter model driving the pads and both clocks
// Assumes: four system cycles per serial bit, clocks high 2 and low 2
// Notes:   pads rest high (weak pull-up) between words
`timescale 1ns/1ps
module lrd_tx_model (
  output logic      o_pos,     // positive pad
  output logic      o_neg,     // negative pad
  output logic      o_bclk,    // serial bit clock
  output logic      o_wclk,    // parallel word clock
  input  wire logic i_clk_sys  // system clock
);
  initial begin
    o_pos = 1'b1;
    o_neg = 1'b1;
    o_bclk = 1'b0;
    o_wclk = 1'b0;
  end

  // msb first; the word clock rises together with the last bit
  task automatic send_word(input logic [7:0] w, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(negedge i_clk_sys);
      o_pos = w[i];
      o_neg = ~w[i];
      o_bclk = 1'b1;
      o_wclk = (i == 0);
      repeat (2) @(negedge i_clk_sys);
      o_bclk = 1'b0;
      o_wclk = 1'b0;
      @(negedge i_clk_sys);
    end
    o_pos = 1'b1;
    o_neg = 1'b1;
  endtask

  task automatic drive_level(input logic b);
    @(negedge i_clk_sys);
    o_pos = b;
    o_neg = ~b;
  endtask
endmodule

// [dv/testbench.sv]
// Purpose: self-checking bench for the lane receive deserializer
// Assumes: word clock driven phase-locked to the bit clock by the model
// Notes:   inputs change on the falling edge of the system clock
`timescale 1ns/1ps
module testbench;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic       deser_en = 1'b1;
  logic [3:0] width = 4'h8;
  logic       conn_alt = 1'b0;
  logic       word_ready = 1'b0;
  logic       overrun_clr = 1'b0;
  logic       pos, neg, bclk, wclk;
  logic [7:0] word;
  logic       valid, rx_bit, alt_out, pll_ref, overrun;
  int         n_mismatch = 0;
  int         checked = 0;

  always #12.5 clk_sys = ~clk_sys;

  lrd_tx_model lrd_tx_model_inst (.o_pos(pos), .o_neg(neg), .o_bclk(bclk), .o_wclk(wclk),
    .i_clk_sys(clk_sys));

  lrd_rx_deser lrd_rx_deser_inst (.i_clk_sys(clk_sys), .i_rst_n(rst_n),
    .i_diff_pos_pad(pos), .i_diff_neg_pad(neg), .i_serial_bit_clock(bclk),
    .i_parallel_word_clock(wclk), .i_deser_en(deser_en), .i_deser_width(width),
    .i_conn_alt(conn_alt), .i_word_ready(word_ready), .i_overrun_clr(overrun_clr),
    .o_parallel_rx_word(word), .o_word_valid(valid), .o_rx_bit(rx_bit),
    .o_bypass_alt_out(alt_out), .o_pll_ref_input(pll_ref), .o_overrun(overrun));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // waits for a word under a bound, compares it, then takes it for one edge
  task automatic take_word(input logic [7:0] exp);
    int k;
    k = 0;
    while (valid !== 1'b1 && k < 200) begin
      @(negedge clk_sys);
      k++;
    end
    check({7'h0, valid}, 8'h01);
    check(word, exp);
    word_ready = 1'b1;
    @(negedge clk_sys);
    word_ready = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic t_widths();
    for (int n = 2; n <= 8; n++) begin
      width = 4'(n);
      lrd_tx_model_inst.send_word(8'ha5, n);
      take_word(8'ha5 & 8'((16'h1 << n) - 16'h1));
    end
  endtask

  task automatic t_short();
    width = 4'h4;
    lrd_tx_model_inst.send_word(8'h0f, 3);
    repeat (20) @(negedge clk_sys);
    check({7'h0, valid}, 8'h00);
    lrd_tx_model_inst.send_word(8'h09, 4);
    take_word(8'h09);
  endtask

  task automatic t_bypass(input logic en, input logic [3:0] w);
    deser_en = en;
    width = w;
    conn_alt = 1'b0;
    for (int b = 1; b >= 0; b--) begin
      lrd_tx_model_inst.drive_level(1'(b));
      repeat (5) @(negedge clk_sys);
      check({7'h0, rx_bit}, 8'(b));
      check({7'h0, alt_out}, 8'h00);
    end
    lrd_tx_model_inst.send_word(8'h03, 2);
    repeat (12) @(negedge clk_sys);
    check({7'h0, valid}, 8'h00);
  endtask

  task automatic t_alt();
    deser_en = 1'b0;
    conn_alt = 1'b1;
    for (int b = 1; b >= 0; b--) begin
      lrd_tx_model_inst.drive_level(1'(b));
      repeat (5) @(negedge clk_sys);
      check({6'h0, alt_out, pll_ref}, 8'(b * 3));
      check({7'h0, rx_bit}, 8'h00);
    end
    deser_en = 1'b1;
    width = 4'h4;
    lrd_tx_model_inst.drive_level(1'b1);
    repeat (5) @(negedge clk_sys);
    check({7'h0, alt_out}, 8'h00);
    conn_alt = 1'b0;
  endtask

  // fill past capacity with the core stalled, then drain in order
  task automatic t_fifo();
    width = 4'h8;
    for (int i = 0; i < 18; i++) lrd_tx_model_inst.send_word(8'h30 + 8'(i), 8);
    repeat (4) @(negedge clk_sys);
    check({7'h0, overrun}, 8'h01);
    for (int i = 0; i < 17; i++) take_word(8'h30 + 8'(i));
    repeat (4) @(negedge clk_sys);
    check({7'h0, valid}, 8'h00);
    overrun_clr = 1'b1;
    @(negedge clk_sys);
    overrun_clr = 1'b0;
    @(negedge clk_sys);
    check({7'h0, overrun}, 8'h00);
  endtask

  task automatic finish_test();
    $display("mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_widths();
    t_short();
    t_bypass(1'b0, 4'h4);
    t_bypass(1'b1, 4'h1);
    t_alt();
    t_fifo();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end
endmodule
